// [src/spess_top.sv]
// two-wire serial slave for a 256-byte presence-detect eeprom with page writes and protection
// assumes a master drives scl and an external pull-up resolves sda from sda_oe_n
//
// Summary of operation
// - sda falling while scl high is taken as a start.
// - sda rising while scl high is taken as a stop.
// - sda changes during scl high are only start or stop, never data.
// - a driver changes sda only while scl is low.
// - one scl pulse per bit, eight bits per byte.
// - bytes travel most significant bit first.
// - after reset or idle, everything is ignored until a start.
// - each received byte is acknowledged by pulling sda low on the ninth pulse; the code leaves refused data bytes unacknowledged.
// - three select pins must match the address bits; eight devices may share.
// - an unconnected select pin reads as zero.
// - write-protect high blocks every array write.
// - write-protect low allows writes, subject to software protection.
// - after a protection command, writes to 00h-7Fh are refused.
// - lower half protection is either permanent or reversible, by command.
// - 256 bytes in pages of sixteen.
// - byte writes, page writes up to sixteen, and partial pages.
// - internal programming is self-timed and ends within 5 ms.
// - type nibble 1010 is memory, 0110 is protection; others ignored.
// - address lsb one reads, zero writes.
// - page writes advance only the low four address bits, wrapping in the page.
// - no acknowledge or response while programming.
`timescale 1ns/1ps
module spess_top #(
  parameter int unsigned PROG_CYCLES = spess_pkg::PROG_CYCLES_DEF
) (
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe_n,
  input  wire logic device_select_bit0,
  input  wire logic device_select_bit1,
  input  wire logic device_select_bit2,
  input  wire logic write_protect,
  output logic      write_busy
);
  import spess_pkg::*;

  typedef struct packed {
    spess_state_e            state;
    spess_kind_e             kind;
    logic [3:0]              cnt;
    logic [7:0]              sreg;
    logic [7:0]              ptr;
    logic [3:0]              page;
    logic                    scl_q;
    logic                    sda_q;
    logic                    oe_n_q;
    logic                    out_q;
    logic                    busy_q;
    spess_tmr_t              tmr;
    logic [PAGE_BYTES-1:0][7:0] wbuf;
    logic [PAGE_BYTES-1:0]   mask;
    spess_pop_e              pop;
    logic                    swp;
    logic                    pswp;
    logic                    mack;
  } spess_top_s;

  spess_top_s s;
  spess_top_s n;

  spess_pins_s pins_raw;
  spess_pins_s pins;
  logic        scl_c;
  logic        sda_c;
  logic        start_ev;
  logic        stop_ev;
  logic        scl_rise;
  logic        scl_fall;
  logic        commit;
  logic [7:0]  rd_byte;
  logic [7:0]  col_rd [PAGE_BYTES];
  logic        sel_match;
  logic        wr_block;

  // all pins, including select and protect straps, cross through four flops
  assign pins_raw = '{wp: write_protect,
                      sel: {device_select_bit2, device_select_bit1, device_select_bit0},
                      sda: sda_in, scl: scl_in};

  spess_sync u_sync (
    .mclk     (mclk),
    .reset    (reset),
    .pins_in  (pins_raw),
    .pins_out (pins)
  );

  assign scl_c = pins.scl;
  assign sda_c = pins.sda;

  // bus events from the filtered levels and their previous values
  assign start_ev = scl_c && s.scl_q && s.sda_q && !sda_c;
  assign stop_ev  = scl_c && s.scl_q && !s.sda_q && sda_c;
  assign scl_rise = scl_c && !s.scl_q;
  assign scl_fall = !scl_c && s.scl_q;

  // programming window ends on the cycle the timer reaches zero
  assign commit = s.busy_q && (s.tmr == '0);

  // floating select pins are expected to be pulled to zero at the board
  assign sel_match = (s.sreg[SEL_MSB:SEL_LSB] == pins.sel);

  // pin protection covers the whole array, software only the lower half
  assign wr_block = pins.wp
                  || ((s.swp || s.pswp) && !s.ptr[PROT_BIT]);

  // array split into one column per byte lane so a page commits in one cycle
  for (genvar g = 0; g < PAGE_BYTES; g++) begin : g_col
    logic [7:0] col [PAGE_COUNT];
    always_ff @(posedge mclk) begin
      if (commit && s.mask[g]) begin
        col[s.page] <= s.wbuf[g];
      end
    end
    assign col_rd[g] = col[s.ptr[7:4]];
  end

  assign rd_byte = col_rd[s.ptr[3:0]];

  // next state of the whole engine
  always_comb begin
    n       = s;
    n.scl_q = scl_c;
    n.sda_q = sda_c;
    n.out_q = 1'b0;

    // self-timed programming countdown
    if (s.busy_q) begin
      if (commit) begin
        n.busy_q = 1'b0;
        n.mask   = '0;
        unique case (s.pop)
          PO_SET:  n.swp  = 1'b1;
          PO_CLR:  n.swp  = 1'b0;
          PO_PERM: n.pswp = 1'b1;
          PO_NONE: n.swp  = s.swp;
        endcase
        n.pop = PO_NONE;
      end else begin
        n.tmr = s.tmr - 1'b1;
      end
    end

    if (start_ev) begin
      // start always restarts framing; an unfinished write is dropped
      n.state  = ST_RX;
      n.kind   = K_DEV;
      n.cnt    = '0;
      n.oe_n_q = 1'b1;
      if (!s.busy_q) begin
        n.mask = '0;
        n.pop  = PO_NONE;
      end
    end else if (stop_ev) begin
      n.state  = ST_IDLE;
      n.oe_n_q = 1'b1;
      if (!s.busy_q && ((s.mask != '0) || (s.pop != PO_NONE))) begin
        n.busy_q = 1'b1;
        n.tmr    = TMR_W'(PROG_CYCLES - 1);
      end
    end else begin
      unique case (s.state)
        ST_IDLE: begin
          n.oe_n_q = 1'b1;
        end

        ST_RX: begin
          if (scl_rise && (s.cnt != BYTE_LAST_BIT)) begin
            n.sreg = {s.sreg[6:0], sda_c};
            n.cnt  = s.cnt + 1'b1;
          end else if (scl_fall && (s.cnt == BYTE_LAST_BIT)) begin
            // drive the acknowledge only after scl is low
            n.state  = ST_ACK;
            n.oe_n_q = 1'b0;
            unique case (s.kind)
              K_DEV: begin
                if (s.busy_q) begin
                  n.state  = ST_IDLE;
                  n.oe_n_q = 1'b1;
                end else if ((s.sreg[TYPE_MSB:TYPE_LSB] == DEV_MEM) && sel_match) begin
                  n.kind = s.sreg[RW_BIT] ? K_TX : K_WADDR;
                end else if (s.sreg[TYPE_MSB:TYPE_LSB] == DEV_PROT) begin
                  if (s.sreg[RW_BIT]) begin
                    // protection read acks set/clear codes when unprotected, a matching select when not permanently protected
                    n.kind = K_DONE;
                    if ((s.sreg[SEL_MSB:SEL_LSB] == SEL_SET) || (s.sreg[SEL_MSB:SEL_LSB] == SEL_CLR)) begin
                      n.oe_n_q = s.swp || s.pswp;
                    end else begin
                      n.oe_n_q = s.pswp || !sel_match;
                    end
                    n.state = n.oe_n_q ? ST_IDLE : ST_ACK;
                  end else if (s.pswp) begin
                    // permanent protection can no longer be changed
                    n.state  = ST_IDLE;
                    n.oe_n_q = 1'b1;
                  end else begin
                    n.kind = K_PDUMMY;
                    if (s.sreg[SEL_MSB:SEL_LSB] == SEL_SET) begin
                      n.pop = PO_SET;
                    end else if (s.sreg[SEL_MSB:SEL_LSB] == SEL_CLR) begin
                      n.pop = PO_CLR;
                    end else if (sel_match) begin
                      n.pop = PO_PERM;
                    end else begin
                      n.state  = ST_IDLE;
                      n.oe_n_q = 1'b1;
                    end
                  end
                end else begin
                  n.state  = ST_IDLE;
                  n.oe_n_q = 1'b1;
                end
              end
              K_WADDR: begin
                n.ptr  = s.sreg;
                n.page = s.sreg[7:4];
                n.mask = '0;
                n.kind = K_DATA;
              end
              K_DATA: begin
                if (wr_block) begin
                  // refused data is not acknowledged and not stored
                  n.state  = ST_IDLE;
                  n.oe_n_q = 1'b1;
                end else begin
                  n.wbuf[s.ptr[3:0]] = s.sreg;
                  n.mask[s.ptr[3:0]] = 1'b1;
                  n.ptr              = {s.ptr[7:4], s.ptr[3:0] + 4'h1};
                end
              end
              K_PDUMMY: begin
                n.kind = K_PDUMMY;   // dummy bytes of a protection command
              end
              K_TX, K_DONE: begin
                n.state  = ST_IDLE;
                n.oe_n_q = 1'b1;
              end
              default: begin
                n.state  = ST_IDLE;
                n.oe_n_q = 1'b1;
              end
            endcase
          end
        end

        ST_ACK: begin
          if (scl_fall) begin
            n.oe_n_q = 1'b1;
            n.cnt    = '0;
            if (s.kind == K_TX) begin
              // first read byte goes out on the same low phase
              n.state  = ST_TX;
              n.sreg   = rd_byte;
              n.oe_n_q = rd_byte[7];
              n.ptr    = s.ptr + 8'h01;
            end else if (s.kind == K_DONE) begin
              n.state = ST_IDLE;
            end else begin
              n.state = ST_RX;
            end
          end
        end

        ST_TX: begin
          if (scl_fall) begin
            n.cnt = s.cnt + 1'b1;
            if (s.cnt == TX_LAST_BIT) begin
              n.state  = ST_RACK;
              n.oe_n_q = 1'b1;
            end else begin
              n.sreg   = {s.sreg[6:0], 1'b0};
              n.oe_n_q = s.sreg[6];
            end
          end
        end

        ST_RACK: begin
          if (scl_rise) begin
            n.mack = !sda_c;
          end else if (scl_fall) begin
            n.cnt = '0;
            if (s.mack) begin
              // sequential read rolls over the whole array
              n.state  = ST_TX;
              n.sreg   = rd_byte;
              n.oe_n_q = rd_byte[7];
              n.ptr    = s.ptr + 8'h01;
            end else begin
              n.state = ST_IDLE;
            end
          end
        end

        default: begin
          n.state  = ST_IDLE;
          n.oe_n_q = 1'b1;
        end
      endcase
    end
  end

  // protection flags reset clear; a real part keeps them in the array
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      s <= '{state: ST_IDLE, kind: K_DEV, cnt: 4'h0, sreg: 8'h00, ptr: 8'h00, page: 4'h0,
             scl_q: 1'b1, sda_q: 1'b1, oe_n_q: 1'b1, out_q: 1'b0, busy_q: 1'b0,
             tmr: '0, wbuf: '0, mask: '0, pop: PO_NONE, swp: 1'b0, pswp: 1'b0, mack: 1'b0};
    end else begin
      s <= n;
    end
  end

  assign sda_oe_n   = s.oe_n_q;
  assign sda_out    = s.out_q;
  assign write_busy = s.busy_q;

endmodule : spess_top

// [src/spess_pkg.sv]
// shared constants, types and carriers for the two-wire serial presence-detect eeprom slave
// assumes a single 40 MHz clock domain and pins that arrive asynchronously to it
package spess_pkg;

  // clock and self-timed programming window
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned PROG_TIME_NS  = 5000000;
  // longest time, so rounded down to whole cycles
  localparam int unsigned PROG_CYCLES_DEF = PROG_TIME_NS / CLK_PERIOD_NS;
  localparam int unsigned TMR_W           = 18;
  typedef logic [TMR_W-1:0] spess_tmr_t;

  // array organisation
  localparam int unsigned MEM_BYTES   = 256;
  localparam int unsigned PAGE_BYTES  = 16;
  localparam int unsigned PAGE_COUNT  = MEM_BYTES / PAGE_BYTES;
  localparam int unsigned PROT_BIT    = 7;     // address bit clear means lower half
  localparam logic [3:0]  BYTE_LAST_BIT = 4'h8;
  localparam logic [3:0]  TX_LAST_BIT   = 4'h7;

  // slave address fields
  localparam logic [3:0] DEV_MEM   = 4'ha;
  localparam logic [3:0] DEV_PROT  = 4'h6;
  localparam logic [2:0] SEL_SET   = 3'h1;
  localparam logic [2:0] SEL_CLR   = 3'h3;
  localparam int unsigned TYPE_MSB = 7;
  localparam int unsigned TYPE_LSB = 4;
  localparam int unsigned SEL_MSB  = 3;
  localparam int unsigned SEL_LSB  = 1;
  localparam int unsigned RW_BIT   = 0;

  // synchroniser depth is fixed at three stages
  localparam int unsigned SYNC_STAGES = 3;

  // bus engine states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_RX   = 5'h02,
    ST_ACK  = 5'h04,
    ST_TX   = 5'h08,
    ST_RACK = 5'h10
  } spess_state_e;

  // what the byte in flight means
  typedef enum logic [2:0] {
    K_DEV    = 3'h0,
    K_WADDR  = 3'h1,
    K_DATA   = 3'h2,
    K_PDUMMY = 3'h3,
    K_TX     = 3'h4,
    K_DONE   = 3'h5
  } spess_kind_e;

  // protection operation waiting for a stop
  typedef enum logic [1:0] {
    PO_NONE = 2'h0,
    PO_SET  = 2'h1,
    PO_CLR  = 2'h2,
    PO_PERM = 2'h3
  } spess_pop_e;

  // pins that go through the synchroniser
  typedef struct packed {
    logic       wp;
    logic [2:0] sel;
    logic       sda;
    logic       scl;
  } spess_pins_s;

  localparam spess_pins_s PINS_RST = '{wp: 1'b0, sel: 3'h0, sda: 1'b1, scl: 1'b1};

endpackage : spess_pkg

// [src/spess_sync.sv]
// three-stage pin synchroniser with agreement filter
// assumes pins are asynchronous to mclk; a change is taken once stages two and three agree
`timescale 1ns/1ps
module spess_sync (
  input  wire logic                 mclk,
  input  wire logic                 reset,
  input  wire spess_pkg::spess_pins_s pins_in,
  output spess_pkg::spess_pins_s    pins_out
);
  import spess_pkg::*;

  typedef struct packed {
    spess_pins_s s1;
    spess_pins_s s2;
    spess_pins_s s3;
    spess_pins_s clean;
  } spess_sync_s;

  spess_sync_s q;
  spess_sync_s d;

  // stage one feeds stage two only; the filter looks at two and three
  always_comb begin
    d    = q;
    d.s1 = pins_in;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.clean = (q.s2 == q.s3) ? q.s3 : q.clean;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      q <= '{s1: PINS_RST, s2: PINS_RST, s3: PINS_RST, clean: PINS_RST};
    end else begin
      q <= d;
    end
  end

  assign pins_out = q.clean;

endmodule : spess_sync

// [testbench/spess_chk.sv]
// concurrent checks on the eeprom serial slave pins, bound to its top
// assumes pins are sampled on mclk with no filter, so pin events lead the design's view
`timescale 1ns/1ps
module spess_chk #(
  parameter int unsigned PROG_CYCLES = 20
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic write_busy
);
  import spess_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  logic       scl_q;
  logic       sda_q;
  logic       seen_q;
  logic [3:0] rise_q;
  logic [7:0] stop_q;
  spess_tmr_t busy_q;

  // pin events at mclk: start seen, scl rises since start, age of last stop, busy length
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      seen_q <= 1'b0;
      rise_q <= 4'h0;
      stop_q <= 8'hff;
      busy_q <= '0;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      if (scl_in && scl_q && sda_q && !sda_in) begin
        seen_q <= 1'b1;
        rise_q <= 4'h0;
      end else if (scl_in && !scl_q && rise_q != 4'hf) begin
        rise_q <= rise_q + 4'h1; // saturates, only the first eight matter
      end
      if (scl_in && scl_q && !sda_q && sda_in) begin
        stop_q <= 8'h00;
      end else if (stop_q != 8'hff) begin
        stop_q <= stop_q + 8'h01;
      end
      busy_q <= write_busy ? busy_q + 1'b1 : '0;
    end
  end

  sequence bus_start;
    scl_in && sda_in ##1 scl_in && !sda_in;
  endsequence

  reset_idle_a: assert property ($fell(reset) |-> sda_oe_n && !write_busy)
    else $error("device active right after reset");
  low_only_a: assert property (!sda_out)
    else $error("sda data value not low");
  quiet_start_a: assert property (!sda_oe_n |-> seen_q)
    else $error("sda driven before any start");
  start_quiet_a: assert property (bus_start |-> ##1 sda_oe_n [*4])
    else $error("sda driven right after start");
  ninth_pulse_a: assert property (!sda_oe_n |-> rise_q >= 4'h8)
    else $error("sda driven within first byte");
  scl_low_a: assert property ($changed(sda_oe_n) |-> !scl_in)
    else $error("sda drive changed while scl high");
  busy_quiet_a: assert property (write_busy |-> sda_oe_n)
    else $error("sda driven while programming");
  busy_len_a: assert property ($fell(write_busy) |-> busy_q == spess_tmr_t'(PROG_CYCLES))
    else $error("programming window length wrong");
  busy_stop_a: assert property ($rose(write_busy) |-> stop_q <= 8'd12)
    else $error("programming began without a stop");

  start_ack_c: cover property (bus_start ##[1:400] !sda_oe_n);
endmodule : spess_chk

bind spess_top spess_chk #(.PROG_CYCLES(PROG_CYCLES)) u_chk (
  .mclk      (mclk),
  .reset     (reset),
  .scl_in    (scl_in),
  .sda_in    (sda_in),
  .sda_out   (sda_out),
  .sda_oe_n  (sda_oe_n),
  .write_busy(write_busy)
);

// [testbench/spess_master.sv]
// two-wire bus master model, driven by bench calls into its tasks
// assumes a pull-up: sda_drv high means released; changes land at mclk falling edges
`timescale 1ns/1ps
module spess_master #(
  parameter int Q = 8
) (
  input  wire logic mclk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_drv
);
  // bus idle: clock parked high, data released
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end

  task automatic qwait;
    repeat (Q) @(negedge mclk); // quarter bit, well above the slave's filter delay
  endtask : qwait

  // start from idle or as a repeated start
  task automatic start;
    sda_drv = 1'b1;
    qwait();
    scl = 1'b1;
    qwait();
    sda_drv = 1'b0;
    qwait();
    scl = 1'b0;
    qwait();
  endtask : start

  task automatic stop;
    sda_drv = 1'b0;
    qwait();
    scl = 1'b1;
    qwait();
    sda_drv = 1'b1;
    qwait();
  endtask : stop

  // one clock pulse per bit, data set only while scl low
  task automatic bit_io(input logic b, output logic r);
    sda_drv = b;
    qwait();
    scl = 1'b1;
    qwait();
    r = sda_line;
    qwait();
    scl = 1'b0;
    qwait();
  endtask : bit_io

  // byte plus acknowledge slot; last=1 releases the slot
  task automatic xfer(input logic [7:0] tx, input logic last, output logic [7:0] rx, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], r);
      rx[i] = r;
    end
    bit_io(last, r);
    ack = ~r;
  endtask : xfer
endmodule : spess_master

// [testbench/tb_spess_eeprom_serial_slave.sv]
// self-checking bench for the eeprom serial slave with a bus master model
// assumes a pull-up on sda and a shortened programming window
`timescale 1ns/1ps
module tb_spd_eeprom_serial_slave;
  import spess_pkg::*;
  localparam int unsigned PROG = 2000; // long enough to poll inside it
  localparam logic [7:0] DEVW = {DEV_MEM, 3'h0, 1'b0};

  logic       mclk;
  logic       reset;
  logic       wp;
  logic [2:0] sel;
  logic       scl;
  logic       m_sda;
  logic       oe_n;
  logic       sda_o;
  logic       busy;
  wire        sda_w;
  int         fails;
  int         checked;

  // open-drain wire with pull-up
  assign sda_w = m_sda & (oe_n | sda_o);

  always #12.5 mclk = ~mclk;

  spess_top #(.PROG_CYCLES(PROG)) dut (
    .mclk(mclk), .reset(reset), .scl_in(scl), .sda_in(sda_w), .sda_out(sda_o), .sda_oe_n(oe_n),
    .device_select_bit0(sel[0]), .device_select_bit1(sel[1]), .device_select_bit2(sel[2]),
    .write_protect(wp), .write_busy(busy)
  );

  spess_master #(.Q(8)) m (.mclk(mclk), .sda_line(sda_w), .scl(scl), .sda_drv(m_sda));

  task automatic test_done;
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done

  task automatic chk_b(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_b

  task automatic chk_v(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_v

  // one byte from the master, device answer compared
  task automatic put(input logic [7:0] b, input logic exp);
    logic [7:0] rx;
    logic       a;
    m.xfer(b, 1'b1, rx, a);
    chk_b(a, exp);
  endtask : put

  // programming window must be open, then close in bounded time
  task automatic wait_idle;
    int n;
    n = 0;
    chk_b(busy, 1'b1);
    while (busy !== 1'b0 && n < 3000) begin
      @(negedge mclk);
      n++;
    end
    chk_b(busy, 1'b0);
  endtask : wait_idle

  task automatic wr1(input logic [7:0] a, input logic [7:0] d, input logic ok);
    m.start();
    put(DEVW, 1'b1);
    put(a, 1'b1);
    put(d, ok);
    m.stop();
    if (ok) wait_idle();
  endtask : wr1

  // random read: address set, repeated start, one byte, master nack
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] rx;
    logic       ak;
    m.start();
    put(DEVW, 1'b1);
    put(a, 1'b1);
    m.start();
    put(DEVW | 8'h01, 1'b1);
    m.xfer(8'hff, 1'b1, rx, ak);
    m.stop();
    chk_v(rx, exp);
  endtask : rd

  task automatic s_noise;
    logic [7:0] rx;
    logic       ak;
    m.xfer(DEVW, 1'b1, rx, ak);
    chk_b(ak, 1'b0);
    m.stop();
  endtask : s_noise

  task automatic s_write;
    m.start();
    put(DEVW, 1'b1);
    put(8'h85, 1'b1);
    put(8'h3c, 1'b1);
    m.stop();
    m.start();
    put(DEVW, 1'b0);
    m.stop();
    wait_idle();
    rd(8'h85, 8'h3c);
    wp = 1'b1;
    wr1(8'h85, 8'h77, 1'b0);
    wp = 1'b0;
    rd(8'h85, 8'h3c);
  endtask : s_write

  // partial page starting near the page end must wrap inside the page
  task automatic s_page;
    logic [7:0] pa [3];
    pa = '{8'h9e, 8'h9f, 8'h90};
    m.start();
    put(DEVW, 1'b1);
    put(8'h9e, 1'b1);
    for (int i = 0; i < 3; i++) put(8'ha1 + 8'(i), 1'b1);
    m.stop();
    wait_idle();
    for (int i = 0; i < 3; i++) rd(pa[i], 8'ha1 + 8'(i));
  endtask : s_page

  task automatic s_select;
    sel = 3'h5;
    for (int s = 0; s < 8; s++) begin
      m.start();
      put({DEV_MEM, 3'(s), 1'b0}, s == 5);
      m.stop();
    end
    m.start();
    put({4'hb, 3'h5, 1'b0}, 1'b0);
    m.stop();
    sel = 3'h0;
  endtask : s_select

  task automatic s_prot;
    m.start();
    put({DEV_PROT, SEL_SET, 1'b0}, 1'b1);
    put(8'h00, 1'b1);
    m.stop();
    wait_idle();
    wr1(8'h10, 8'h99, 1'b0);
    wr1(8'ha5, 8'h5a, 1'b1);
    rd(8'ha5, 8'h5a);
    m.start();
    put({DEV_PROT, SEL_SET, 1'b1}, 1'b0);
    m.stop();
    m.start();
    put({DEV_PROT, SEL_CLR, 1'b0}, 1'b1);
    put(8'h00, 1'b1);
    m.stop();
    wait_idle();
    wr1(8'h10, 8'h99, 1'b1);
    rd(8'h10, 8'h99);
    m.start();
    put({DEV_PROT, 3'h0, 1'b0}, 1'b1);
    put(8'h00, 1'b1);
    m.stop();
    wait_idle();
    m.start();
    put({DEV_PROT, SEL_CLR, 1'b0}, 1'b0);
    m.stop();
    wr1(8'h10, 8'h44, 1'b0);
  endtask : s_prot

  // main sequence: reset for three cycles, settle, then the scenarios
  initial begin
    mclk = 1'b0;
    reset = 1'b1;
    wp = 1'b0;
    sel = 3'h0;
    fails = 0;
    checked = 0;
    repeat (3) @(negedge mclk);
    reset = 1'b0;
    repeat (6) @(negedge mclk);
    s_noise();
    s_write();
    s_page();
    s_select();
    s_prot();
    test_done();
  end

  // watchdog: about two and a half times the expected run
  initial begin
    repeat (90000) @(posedge mclk);
    fails++;
    test_done();
  end
endmodule : tb_spd_eeprom_serial_slave
